// ### design/fspc_pkg.sv
// constants for the flash self-programming controller
package fspc_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_PTR    = 8'h00;
  localparam logic [7:0] OFS_LATCH  = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_KEY    = 8'h0C;
  localparam logic [7:0] OFS_TBLOP  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ****************************************
  // mem_control_reg bit positions
  // ****************************************
  localparam int CTL_PROG_SPACE = 7;
  localparam int CTL_CFG_SPACE  = 6;
  localparam int CTL_ROW_ERASE  = 4;
  localparam int CTL_WR_ERR     = 3;
  localparam int CTL_WRITE_ENABLE_BIT       = 2;
  localparam int CTL_GO         = 1;

  // ****************************************
  // table op command and status fields
  // ****************************************
  localparam int TOP_WRITE  = 0;
  localparam int TOP_MODE_L = 1;
  localparam int ST_DONE    = 0;
  localparam int ST_BUSY    = 1;
  localparam int ST_KEY_L   = 2;

  // ****************************************
  // widths and geometry
  // ****************************************
  localparam int PTR_W     = 22;
  localparam int PTR_MOD_W = 21;
  localparam int HOLD_N    = 8;
  localparam int HOLD_SEL  = 3;
  localparam int ROW_LSB   = 6;
  localparam int BLK_LSB   = 3;

  // ****************************************
  // unlock key values
  // ****************************************
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // ****************************************
  // long write timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int LONG_WRITE_NS = 2000000;
  localparam int LONG_WRITE_CYC = LONG_WRITE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PTR_KEEP,
    PTR_POST_INC,
    PTR_POST_DEC,
    PTR_PRE_INC
  } fspc_ptr_mode_t;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_GOT_FIRST,
    KEY_ARMED
  } fspc_key_t;

endpackage : fspc_pkg

// ### design/fspc_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module fspc_sync (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // asynchronous level in, filtered level out
  input  wire logic async_i,
  output logic      level_o
);

  logic q1;
  logic q2;
  logic q3;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q1 <= 1'b0;
      q2 <= 1'b0;
      q3 <= 1'b0;
    end else begin
      q1 <= async_i;
      q2 <= q1;
      q3 <= q2;
    end
  end

  // change only when second and third stage agree
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else if (q2 == q3) begin
      level_o <= q3;
    end
  end

endmodule : fspc_sync

// ### design/fspc_timer.sv
// dedicated nonvolatile write timer
`timescale 1ns/100ps
module fspc_timer #(
  parameter int CYCLES = fspc_pkg::LONG_WRITE_CYC
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic start_i,
  input  wire logic abort_i,
  output logic      done_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

  logic [CW-1:0] count;
  logic          run;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count  <= '0;
      run    <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        run <= 1'b0;
      end else if (start_i) begin
        count <= LOAD;
        run   <= 1'b1;
      end else if (run) begin
        if (count == '0) begin
          run    <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

endmodule : fspc_timer

// ### design/fspc_ctrl.sv
// flash self-programming controller with apb register access
`timescale 1ns/100ps

module fspc_ctrl #(
  parameter int LONG_CYC = fspc_pkg::LONG_WRITE_CYC
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // flash array
  output logic [20:0]      flash_addr_o,
  output logic             flash_rd_o,
  input  wire logic [15:0] flash_rdata_i,
  output logic             flash_erase_o,
  output logic             flash_prog_o,
  output logic [63:0]      flash_wdata_o,
  // reset requests from pins, cpu stall
  input  wire logic        mclr_req_i,
  input  wire logic        wdt_req_i,
  output logic             cpu_stall_o
);

  // ****************************************
  // state and storage
  // ****************************************
  typedef enum logic [1:0] {
    S_IDLE,
    S_RD_ADDR,
    S_RD_CAP,
    S_LONG
  } fspc_state_t;

  fspc_state_t            state;
  fspc_pkg::fspc_key_t    key_st;
  logic [fspc_pkg::PTR_W-1:0] table_pointer;
  logic [7:0]             table_latch;
  logic [7:0]             hold [fspc_pkg::HOLD_N];
  logic                   program_space_select;
  logic                   config_space_select;
  logic                   row_erase_select;
  logic                   write_enable_bit;
  logic                   program_go_bit;
  logic                   interrupted_program_flag;
  logic                   nvm_done_flag;
  logic                   taken;
  logic                   byte_hi;
  logic                   mclr_lvl;
  logic                   wdt_lvl;
  logic                   timer_done;

  // ****************************************
  // request decode
  // ****************************************
  logic                   take;
  logic                   wr_take;
  logic                   mapped;
  logic                   go_ok;
  logic                   tbl_take;
  logic                   abort;
  logic                   finish;
  logic [fspc_pkg::PTR_W-1:0] acc_ptr;
  logic [fspc_pkg::PTR_W-1:0] next_ptr;
  fspc_pkg::fspc_ptr_mode_t   mode;

  assign take    = psel_i && !taken && !pready_o && state == S_IDLE;
  assign wr_take = take && pwrite_i;
  assign mapped  = paddr_i == fspc_pkg::OFS_PTR
                || paddr_i == fspc_pkg::OFS_LATCH
                || paddr_i == fspc_pkg::OFS_CTRL
                || paddr_i == fspc_pkg::OFS_KEY
                || paddr_i == fspc_pkg::OFS_TBLOP
                || paddr_i == fspc_pkg::OFS_STATUS;
  assign tbl_take = wr_take && paddr_i == fspc_pkg::OFS_TBLOP;
  assign mode = fspc_pkg::fspc_ptr_mode_t'(
    pwdata_i[fspc_pkg::TOP_MODE_L +: 2]);
  assign abort  = state == S_LONG && (mclr_lvl || wdt_lvl);
  assign finish = state == S_LONG && timer_done && !abort;

  // go accepted only with enable, program space and fresh unlock
  assign go_ok = wr_take && paddr_i == fspc_pkg::OFS_CTRL
              && pwdata_i[fspc_pkg::CTL_GO]
              && pwdata_i[fspc_pkg::CTL_WRITE_ENABLE_BIT]
              && pwdata_i[fspc_pkg::CTL_PROG_SPACE]
              && !pwdata_i[fspc_pkg::CTL_CFG_SPACE]
              && key_st == fspc_pkg::KEY_ARMED;

  // pre-increment uses the moved pointer for the access
  always_comb begin
    acc_ptr  = table_pointer;
    next_ptr = table_pointer;
    unique case (mode)
      fspc_pkg::PTR_KEEP: begin
        next_ptr = table_pointer;
      end
      fspc_pkg::PTR_POST_INC, fspc_pkg::PTR_PRE_INC: begin
        next_ptr[fspc_pkg::PTR_MOD_W-1:0] =
          table_pointer[fspc_pkg::PTR_MOD_W-1:0] + 1'b1;
      end
      fspc_pkg::PTR_POST_DEC: begin
        next_ptr[fspc_pkg::PTR_MOD_W-1:0] =
          table_pointer[fspc_pkg::PTR_MOD_W-1:0] - 1'b1;
      end
    endcase
    if (mode == fspc_pkg::PTR_PRE_INC) begin
      acc_ptr = next_ptr;
    end
  end

  // ****************************************
  // reset request synchronisers
  // ****************************************
  fspc_sync u_sync_mclr (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (mclr_req_i),
    .level_o    (mclr_lvl)
  );

  fspc_sync u_sync_wdt (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (wdt_req_i),
    .level_o    (wdt_lvl)
  );

  // ****************************************
  // long write timer
  // ****************************************
  fspc_timer #(
    .CYCLES (LONG_CYC)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .start_i    (go_ok),
    .abort_i    (abort),
    .done_o     (timer_done)
  );

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (go_ok) begin
            state <= S_LONG;
          end else if (tbl_take && !pwdata_i[fspc_pkg::TOP_WRITE]) begin
            state <= S_RD_ADDR;
          end
        end
        S_RD_ADDR: begin
          state <= S_RD_CAP;
        end
        S_RD_CAP: begin
          state <= S_IDLE;
        end
        S_LONG: begin
          if (finish || abort) begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // apb handshake
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      taken     <= 1'b0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      if (pready_o) begin
        taken <= 1'b0;
      end else if (take) begin
        taken <= 1'b1;
      end
      // go answers only when the long write ends
      pready_o <= (take && !go_ok
                   && !(tbl_take && !pwdata_i[fspc_pkg::TOP_WRITE]))
               || state == S_RD_CAP || finish || abort;
      if (take) begin
        pslverr_o <= !mapped;
      end else if (pready_o) begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // read data
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (take && !pwrite_i) begin
      prdata_o <= 32'h00000000;
      unique case (paddr_i)
        fspc_pkg::OFS_PTR: begin
          prdata_o[fspc_pkg::PTR_W-1:0] <= table_pointer;
        end
        fspc_pkg::OFS_LATCH: begin
          prdata_o[7:0] <= table_latch;
        end
        fspc_pkg::OFS_CTRL: begin
          prdata_o[fspc_pkg::CTL_PROG_SPACE] <= program_space_select;
          prdata_o[fspc_pkg::CTL_CFG_SPACE]  <= config_space_select;
          prdata_o[fspc_pkg::CTL_ROW_ERASE]  <= row_erase_select;
          prdata_o[fspc_pkg::CTL_WR_ERR]     <= interrupted_program_flag;
          prdata_o[fspc_pkg::CTL_WRITE_ENABLE_BIT]       <= write_enable_bit;
          prdata_o[fspc_pkg::CTL_GO]         <= program_go_bit;
        end
        fspc_pkg::OFS_STATUS: begin
          prdata_o[fspc_pkg::ST_DONE] <= nvm_done_flag;
          prdata_o[fspc_pkg::ST_BUSY] <= state == S_LONG;
          prdata_o[fspc_pkg::ST_KEY_L +: 2] <= key_st;
        end
        default: begin
          prdata_o <= 32'h00000000;
        end
      endcase
    end
  end

  // ****************************************
  // unlock key sequencer
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      key_st <= fspc_pkg::KEY_IDLE;
    end else if (wr_take) begin
      if (paddr_i != fspc_pkg::OFS_KEY) begin
        key_st <= fspc_pkg::KEY_IDLE;
      end else if (pwdata_i[7:0] == fspc_pkg::KEY_FIRST) begin
        key_st <= fspc_pkg::KEY_GOT_FIRST;
      end else if (pwdata_i[7:0] == fspc_pkg::KEY_SECOND
                   && key_st == fspc_pkg::KEY_GOT_FIRST) begin
        key_st <= fspc_pkg::KEY_ARMED;
      end else begin
        key_st <= fspc_pkg::KEY_IDLE;
      end
    end
  end

  // ****************************************
  // table pointer
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      table_pointer <= '0;
      byte_hi       <= 1'b0;
    end else if (wr_take && paddr_i == fspc_pkg::OFS_PTR) begin
      table_pointer <= pwdata_i[fspc_pkg::PTR_W-1:0];
    end else if (tbl_take) begin
      table_pointer <= next_ptr;
      byte_hi       <= acc_ptr[0];
    end
  end

  // ****************************************
  // table latch and holding registers
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      table_latch <= 8'h00;
    end else if (wr_take && paddr_i == fspc_pkg::OFS_LATCH) begin
      table_latch <= pwdata_i[7:0];
    end else if (state == S_RD_CAP) begin
      table_latch <= byte_hi ? flash_rdata_i[15:8]
                             : flash_rdata_i[7:0];
    end
  end

  // requests are only taken in idle, so holding stays put
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < fspc_pkg::HOLD_N; i++) begin
        hold[i] <= 8'hFF;
      end
    end else if (tbl_take && pwdata_i[fspc_pkg::TOP_WRITE]) begin
      hold[acc_ptr[fspc_pkg::HOLD_SEL-1:0]] <= table_latch;
    end
  end

  // ****************************************
  // mem_control_reg
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      program_space_select <= 1'b0;
      config_space_select  <= 1'b0;
      row_erase_select     <= 1'b0;
      write_enable_bit     <= 1'b0;
      program_go_bit       <= 1'b0;
    end else begin
      if (wr_take && paddr_i == fspc_pkg::OFS_CTRL) begin
        program_space_select <= pwdata_i[fspc_pkg::CTL_PROG_SPACE];
        config_space_select  <= pwdata_i[fspc_pkg::CTL_CFG_SPACE];
        row_erase_select     <= pwdata_i[fspc_pkg::CTL_ROW_ERASE];
        write_enable_bit     <= pwdata_i[fspc_pkg::CTL_WRITE_ENABLE_BIT];
      end
      if (go_ok) begin
        program_go_bit <= 1'b1;
      end else if (finish || abort) begin
        program_go_bit   <= 1'b0;
        row_erase_select <= 1'b0;
      end
    end
  end

  // sticky flags; a hardware set wins over a software clear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nvm_done_flag            <= 1'b0;
      interrupted_program_flag <= 1'b0;
    end else begin
      if (finish) begin
        nvm_done_flag <= 1'b1;
      end else if (wr_take && paddr_i == fspc_pkg::OFS_STATUS
                   && pwdata_i[fspc_pkg::ST_DONE]) begin
        nvm_done_flag <= 1'b0;
      end
      if (abort) begin
        interrupted_program_flag <= 1'b1;
      end else if (wr_take && paddr_i == fspc_pkg::OFS_CTRL
                   && !pwdata_i[fspc_pkg::CTL_WR_ERR]) begin
        interrupted_program_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // flash array drive
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_addr_o  <= '0;
      flash_rd_o    <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_prog_o  <= 1'b0;
      cpu_stall_o   <= 1'b0;
    end else begin
      flash_rd_o <= 1'b0;
      if (go_ok) begin
        cpu_stall_o <= 1'b1;
        if (pwdata_i[fspc_pkg::CTL_ROW_ERASE]) begin
          flash_erase_o <= 1'b1;
          flash_addr_o  <= {table_pointer[fspc_pkg::PTR_W-1:
                                          fspc_pkg::ROW_LSB],
                            {(fspc_pkg::ROW_LSB-1){1'b0}}};
        end else begin
          flash_prog_o <= 1'b1;
          flash_addr_o <= {table_pointer[fspc_pkg::PTR_W-1:
                                         fspc_pkg::BLK_LSB],
                           {(fspc_pkg::BLK_LSB-1){1'b0}}};
        end
      end else if (finish || abort) begin
        cpu_stall_o   <= 1'b0;
        flash_erase_o <= 1'b0;
        flash_prog_o  <= 1'b0;
      end else if (tbl_take && !pwdata_i[fspc_pkg::TOP_WRITE]) begin
        flash_rd_o   <= 1'b1;
        flash_addr_o <= acc_ptr[fspc_pkg::PTR_W-1:1];
      end
    end
  end

  // holding bytes in address order, byte 0 lowest
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_wdata_o <= '1;
    end else begin
      for (int i = 0; i < fspc_pkg::HOLD_N; i++) begin
        flash_wdata_o[i*8 +: 8] <= hold[i];
      end
    end
  end

endmodule : fspc_ctrl

// ### testbench/fspc_ctrl_sva.sv
// assertion checker for the flash self-programming controller
`timescale 1ns/100ps
module fspc_ctrl_sva #(
  parameter int LONG_CYC = fspc_pkg::LONG_WRITE_CYC
) (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  // flash, reset requests, stall
  input wire logic [20:0] flash_addr_o,
  input wire logic        flash_rd_o,
  input wire logic        flash_erase_o,
  input wire logic        flash_prog_o,
  input wire logic [63:0] flash_wdata_o,
  input wire logic        mclr_req_i,
  input wire logic        wdt_req_i,
  input wire logic        cpu_stall_o
);
  // ****
  // helper state
  // ****
  logic        act;
  logic        wr_done;
  logic        go_req;
  logic        ok_go;
  logic        ab_seen;
  logic [1:0]  key_st;
  logic [31:0] lw_cnt;
  assign act     = flash_erase_o | flash_prog_o;
  assign wr_done = psel_i & penable_i & pready_o & pwrite_i;
  // go with write_enable_bit, program space, no config space, fresh unlock
  assign go_req  = psel_i & pwrite_i & (paddr_i == fspc_pkg::OFS_CTRL)
                 & (pwdata_i[7:6] == 2'h2) & pwdata_i[2] & pwdata_i[1]
                 & (key_st == 2'h2);
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lw_cnt  <= 32'h0;
      ab_seen <= 1'h0;
    end else begin
      lw_cnt  <= act ? lw_cnt + 32'h1 : 32'h0;
      ab_seen <= act & (ab_seen | mclr_req_i | wdt_req_i);
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      key_st <= 2'h0;
      ok_go  <= 1'h0;
    end else begin
      ok_go <= go_req | (ok_go & ~wr_done);
      if (wr_done) begin
        if (paddr_i == fspc_pkg::OFS_KEY
            && pwdata_i[7:0] == fspc_pkg::KEY_FIRST)
          key_st <= 2'h1;
        else if (paddr_i == fspc_pkg::OFS_KEY && key_st == 2'h1
                 && pwdata_i[7:0] == fspc_pkg::KEY_SECOND)
          key_st <= 2'h2;
        else
          key_st <= 2'h0;
      end
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_stall; cpu_stall_o == act; endproperty
  a_stall: assert property (p_stall)
    else $error("cpu not stalled in long write");
  property p_nordy; act |-> !pready_o; endproperty
  a_nordy: assert property (p_nordy)
    else $error("bus answered during long write");
  property p_excl; !(flash_erase_o && flash_prog_o); endproperty
  a_excl: assert property (p_excl)
    else $error("erase and program together");
  property p_row; flash_erase_o |-> flash_addr_o[4:0] == 5'h0; endproperty
  a_row: assert property (p_row)
    else $error("erase address not row aligned");
  property p_blk; flash_prog_o |-> flash_addr_o[1:0] == 2'h0; endproperty
  a_blk: assert property (p_blk)
    else $error("program address not block aligned");
  property p_len;
    $fell(act) && !ab_seen |-> lw_cnt >= LONG_CYC - 1
      && lw_cnt <= LONG_CYC + 2;
  endproperty
  a_len: assert property (p_len)
    else $error("long write length wrong");
  property p_bound; act |-> lw_cnt <= LONG_CYC + 1; endproperty
  a_bound: assert property (p_bound)
    else $error("long write not ended by timer");
  property p_hold;
    act && $past(act) |-> $stable(flash_wdata_o) && $stable(flash_addr_o)
      && !flash_rd_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("table path moved during long write");
  property p_rd; flash_rd_o |=> !flash_rd_o ##1 pready_o; endproperty
  a_rd: assert property (p_rd)
    else $error("table read not answered in time");
  property p_key; $rose(act) |-> ok_go; endproperty
  a_key: assert property (p_key)
    else $error("long write without valid unlock");
endmodule : fspc_ctrl_sva

bind fspc_ctrl fspc_ctrl_sva #(.LONG_CYC(LONG_CYC)) sva_u (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pready_o(pready_o), .flash_addr_o(flash_addr_o),
  .flash_rd_o(flash_rd_o), .flash_erase_o(flash_erase_o),
  .flash_prog_o(flash_prog_o), .flash_wdata_o(flash_wdata_o),
  .mclr_req_i(mclr_req_i), .wdt_req_i(wdt_req_i),
  .cpu_stall_o(cpu_stall_o)
);

// ### testbench/fspc_flash_model.sv
// flash array model answering reads, row erases and block programs
`timescale 1ns/100ps
module fspc_flash_model (
  // clock
  input  wire logic        core_clk_i,
  // flash port
  input  wire logic [20:0] flash_addr_i,
  input  wire logic        flash_rd_i,
  input  wire logic        flash_erase_i,
  input  wire logic        flash_prog_i,
  input  wire logic [63:0] flash_wdata_i,
  output logic      [15:0] flash_rdata_o
);
  logic [15:0] mem [int];
  logic        er_q = 1'h0;
  logic        pg_q = 1'h0;
  int          w;
  initial flash_rdata_o = 16'h0;
  always @(posedge core_clk_i) begin
    w = int'(flash_addr_i);
    er_q <= flash_erase_i;
    pg_q <= flash_prog_i;
    // data valid only in the cycle after a read strobe
    if (flash_rd_i)
      flash_rdata_o <= mem.exists(w) ? mem[w]
        : {8'(2 * w + 1) ^ 8'h5A, 8'(2 * w) ^ 8'h5A};
    else
      flash_rdata_o <= ~flash_rdata_o;
    if (flash_erase_i && !er_q)
      for (int i = 0; i < 32; i++) mem[(w & ~31) + i] = 16'hFFFF;
    if (flash_prog_i && !pg_q)
      for (int i = 0; i < 4; i++)
        mem[(w & ~3) + i] = flash_wdata_i[16 * i +: 16];
  end
endmodule : fspc_flash_model

// ### testbench/fspc_tb.sv
// self-checking bench for the flash self-programming controller
`timescale 1ns/100ps
module tb;
  // ****
  // design, flash model and clock
  // ****
  localparam int          LC    = 20;
  localparam logic [7:0]  A_PTR = fspc_pkg::OFS_PTR;
  localparam logic [7:0]  A_LAT = fspc_pkg::OFS_LATCH;
  localparam logic [7:0]  A_CTL = fspc_pkg::OFS_CTRL;
  localparam logic [7:0]  A_KEY = fspc_pkg::OFS_KEY;
  localparam logic [7:0]  A_TOP = fspc_pkg::OFS_TBLOP;
  localparam logic [7:0]  A_STA = fspc_pkg::OFS_STATUS;
  localparam logic [31:0] GO_P  = 32'h86;
  localparam logic [31:0] GO_E  = 32'h96;
  logic        clk    = 1'h0;
  logic        rst    = 1'h1;
  logic        psel   = 1'h0;
  logic        pen    = 1'h0;
  logic        pwr    = 1'h0;
  logic [7:0]  paddr  = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic        mclr   = 1'h0;
  logic        wdt    = 1'h0;
  logic        pready, pslverr, frd, fer, fpg, stall, re;
  logic [31:0] prdata, rq, row, blk, p, d;
  logic [20:0] faddr;
  logic [15:0] frdata;
  logic [63:0] fwdata;
  logic [1:0]  m;
  logic [7:0]  shadow [int];
  int          error_cnt = 0;
  int          checks    = 0;
  int          wait_n;
  always #25 clk = ~clk;
  fspc_ctrl #(.LONG_CYC(LC)) dut_u (
    .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .flash_addr_o(faddr), .flash_rd_o(frd), .flash_rdata_i(frdata),
    .flash_erase_o(fer), .flash_prog_o(fpg), .flash_wdata_o(fwdata),
    .mclr_req_i(mclr), .wdt_req_i(wdt), .cpu_stall_o(stall)
  );
  fspc_flash_model fl_u (
    .core_clk_i(clk), .flash_addr_i(faddr), .flash_rd_i(frd),
    .flash_erase_i(fer), .flash_prog_i(fpg), .flash_wdata_i(fwdata),
    .flash_rdata_o(frdata)
  );
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dat);
    wait_n = 0;
    psel   <= 1'h1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= dat;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
      wait_n++;
    end while (pready !== 1'h1 && wait_n < 200);
    if (wait_n >= 200) error_cnt++;
    rq = prdata;
    re = pslverr;
    psel <= 1'h0;
    pen  <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic trd(input logic [31:0] a, input logic [1:0] md);
    apb(1'h1, A_PTR, a);
    apb(1'h1, A_TOP, {29'h0, md, 1'h0});
    apb(1'h0, A_LAT, 32'h0);
  endtask : trd
  task automatic go(input logic [31:0] c);
    apb(1'h1, A_KEY, {24'h0, fspc_pkg::KEY_FIRST});
    apb(1'h1, A_KEY, {24'h0, fspc_pkg::KEY_SECOND});
    apb(1'h1, A_CTL, c);
  endtask : go
  function automatic logic [7:0] exp_b(input logic [31:0] b);
    return shadow.exists(int'(b)) ? shadow[int'(b)] : b[7:0] ^ 8'h5A;
  endfunction : exp_b
  task automatic summarize;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    #(50 * 20000);
    error_cnt++;
    summarize();
  end
  // ****
  // scenarios
  // ****
  initial begin
    void'($urandom(91));
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, 8'h18, 32'h0);
    chk({31'h0, re}, 32'h1);
    // go refused: no key, no write_enable_bit, key broken by another write
    for (int v = 0; v < 3; v++) begin
      if (v == 0) apb(1'h1, A_CTL, GO_E);
      if (v == 1) go(GO_E ^ 32'h4);
      if (v == 2) begin
        apb(1'h1, A_KEY, {24'h0, fspc_pkg::KEY_FIRST});
        apb(1'h1, A_PTR, 32'h40);
        apb(1'h1, A_KEY, {24'h0, fspc_pkg::KEY_SECOND});
        apb(1'h1, A_CTL, GO_E);
      end
      chk(wait_n < 4, 32'h1);
      apb(1'h0, A_STA, 32'h0);
      chk(rq[fspc_pkg::ST_DONE], 32'h0);
    end
    // row erase with unaligned pointer
    row = $urandom & 32'h3FC0;
    apb(1'h1, A_PTR, row | ($urandom & 32'h3F));
    go(GO_E);
    chk(wait_n >= LC, 32'h1);
    for (int i = 0; i < 64; i++) shadow[int'(row) + i] = 8'hFF;
    apb(1'h0, A_STA, 32'h0);
    chk(rq[fspc_pkg::ST_DONE], 32'h1);
    apb(1'h0, A_CTL, 32'h0);
    chk(rq[fspc_pkg::CTL_GO], 32'h0);
    apb(1'h1, A_STA, 32'h1);
    apb(1'h0, A_STA, 32'h0);
    chk(rq[fspc_pkg::ST_DONE], 32'h0);
    trd(row + 63, 2'h0);
    chk(rq[7:0], 32'hFF);
    trd(row + 64, 2'h0);
    chk(rq[7:0], exp_b(row + 64));
    // fill eight holding registers, then program the block
    blk = row + (($urandom & 32'h7) << 3);
    apb(1'h1, A_PTR, blk);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      shadow[int'(blk) + i] = d[7:0];
      apb(1'h1, A_LAT, d);
      apb(1'h1, A_TOP, 32'h3);
    end
    trd(blk + 5, 2'h0);
    chk(rq[7:0], 32'hFF);
    go(GO_P);
    chk(wait_n >= LC, 32'h1);
    for (int i = 0; i < 8; i++) begin
      trd(blk + i, 2'h0);
      chk(rq[7:0], exp_b(blk + i));
    end
    // table reads in every pointer mode
    for (int i = 0; i < 8; i++) begin
      p = (i < 4) ? blk + i : ($urandom & 32'h3FFF) | 32'h1;
      m = 2'(i);
      trd(p, m);
      chk(rq[7:0], exp_b(m == 2'h3 ? p + 1 : p));
      apb(1'h0, A_PTR, 32'h0);
      chk(rq, m == 2'h0 ? p : m == 2'h2 ? p - 1 : p + 1);
    end
    // reset request from each source during an erase
    for (int s = 0; s < 2; s++) begin
      apb(1'h1, A_PTR, 32'h8000 + 32'(s * 64));
      fork
        go(GO_E);
        begin
          repeat (12) @(posedge clk);
          mclr <= (s == 0);
          wdt  <= (s == 1);
          repeat (5) @(posedge clk);
          mclr <= 1'h0;
          wdt  <= 1'h0;
        end
      join
      apb(1'h0, A_CTL, 32'h0);
      chk(rq[fspc_pkg::CTL_WR_ERR], 32'h1);
      apb(1'h1, A_CTL, 32'h0);
    end
    summarize();
  end
endmodule : tb
